// >>> hw/sar_adc_pkg.sv
// constants, field layout and state codes of the sar adc sequencer
package sar_adc_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] CTRL_INDEX = 8'hFA;
  localparam logic [7:0] RESULT_INDEX = 8'hFB;
  localparam logic [7:0] IRQ_STATUS_INDEX = 8'hFC;
  localparam logic [7:0] IRQ_MASK_INDEX = 8'hFD;
  localparam int CHAN_LO = 4;
  localparam int EOC_BIT = 3;
  localparam int SPEED_LO = 1;
  localparam int START_BIT = 0;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [1:0] SPEED_RESET = 2'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam logic [7:0] SAR_MIDPOINT = 8'h80;
  localparam int RESULT_BITS = 8;
  localparam int SETUP_CLOCKS = 18;
  localparam int CLOCKS_PER_BIT = 4;
  localparam int TOTAL_CLOCKS = SETUP_CLOCKS + CLOCKS_PER_BIT * RESULT_BITS;
  localparam int CLK_PERIOD_PS = 5000;
  localparam logic [4:0] SETUP_LAST = 5'(SETUP_CLOCKS - 1);
  localparam logic [4:0] BIT_LAST = 5'(CLOCKS_PER_BIT - 1);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_CONVERT = 3'b100
  } seq_state_type;
endpackage : sar_adc_pkg

// >>> hw/sar_ctrl_if.sv
// signals shared by the register side, the step divider and the sequencer core
`timescale 1ns/1ps
interface sar_ctrl_if;
  logic start;
  logic [1:0] speed;
  logic tick;
  logic busy;
  logic done;
  logic [7:0] sar;
  logic [7:0] result;
  modport host (output start, output speed, input busy, input done, input sar, input result);
  modport div (input start, input speed, output tick);
  modport seq (input start, input tick, output busy, output done, output sar, output result);
endinterface : sar_ctrl_if

// >>> hw/step_divider.sv
// step tick generator: one tick per clock at speed 00, slower for the other codes
`timescale 1ns/1ps
module step_divider
  import sar_adc_pkg::*;
#(
  parameter int DIV_SPEED1 = 2,
  parameter int DIV_SPEED2 = 4,
  parameter int DIV_SPEED3 = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sar_ctrl_if.div ctl
);
  logic [7:0] cnt_q;
  logic [7:0] limit;

  initial begin
    if (DIV_SPEED1 < 1 || DIV_SPEED2 < 1 || DIV_SPEED3 < 1 ||
        DIV_SPEED1 > 255 || DIV_SPEED2 > 255 || DIV_SPEED3 > 255) begin
      $error("step_divider: divide ratios must lie in 1..255");
    end
  end

  always_comb begin
    unique case (ctl.speed)
      2'h0: limit = 8'h01;
      2'h1: limit = 8'(DIV_SPEED1);
      2'h2: limit = 8'(DIV_SPEED2);
      default: limit = 8'(DIV_SPEED3);
    endcase
  end

  assign ctl.tick = (cnt_q == limit - 8'h01);

  // restart on start so the first tick of a run is a full period away
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
    end else if (ctl.start || ctl.tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : step_divider

// >>> hw/sar_core.sv
// successive approximation sequencer: setup phase, eight bit decisions, result load
`timescale 1ns/1ps
module sar_core
  import sar_adc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic comp_above_i,
  sar_ctrl_if.seq ctl
);
  seq_state_type state_q;
  logic [4:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] sar_q;
  logic [7:0] sar_d;
  logic [7:0] result_q;
  logic done_q;

  // keep the bit when the input is at or above the trial level, then try the next lower
  always_comb begin
    sar_d = sar_q;
    sar_d[bit_q] = comp_above_i;
    if (bit_q != 3'h0) begin
      sar_d[bit_q - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      bit_q <= 3'h7;
      sar_q <= SAR_MIDPOINT;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (ctl.start) begin
            state_q <= ST_SETUP;
            cnt_q <= 5'h00;
            bit_q <= 3'(RESULT_BITS - 1);
            sar_q <= SAR_MIDPOINT;
          end
        end
        ST_SETUP: begin
          if (ctl.tick) begin
            if (cnt_q == SETUP_LAST) begin
              state_q <= ST_CONVERT;
              cnt_q <= 5'h00;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (ctl.tick) begin
            if (cnt_q == BIT_LAST) begin
              cnt_q <= 5'h00;
              sar_q <= sar_d;
              if (bit_q == 3'h0) begin
                state_q <= ST_IDLE;
              end else begin
                bit_q <= bit_q - 3'h1;
              end
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // result register loaded only on completion, overwriting any unread value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (state_q == ST_CONVERT && ctl.tick && cnt_q == BIT_LAST && bit_q == 3'h0) begin
        result_q <= sar_d;
        done_q <= 1'b1;
      end
    end
  end

  assign ctl.busy = (state_q != ST_IDLE);
  assign ctl.done = done_q;
  assign ctl.sar = sar_q;
  assign ctl.result = result_q;
endmodule : sar_core

// >>> hw/sar_adc_sequencer.sv
// top of the sar adc sequencer: avalon slave, control and result registers, interrupt
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int DIV_SPEED1 = 2,
  parameter int DIV_SPEED2 = 4,
  parameter int DIV_SPEED3 = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic comp_above_i,
  output logic [7:0] dac_code_o,
  output logic [1:0] channel_sel_o,
  output logic converting_o,
  output logic irq_o
);
  logic rst_meta_q;
  logic rst_n_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] chan_q;
  logic [1:0] conv_chan_q;
  logic [1:0] speed_q;
  logic eoc_q;
  logic start_q;
  logic unread_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic comp_s1_q;
  logic comp_s2_q;
  logic comp_s3_q;
  logic comp_q;
  logic comp_filt;
  logic req;
  logic wr_take;
  logic rd_take;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic [7:0] ctrl_view;
  logic [7:0] rd_mux;

  sar_ctrl_if ctl ();

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] index);
    hit = (addr == {index, 2'b00});
  endfunction : hit

  // release of the asynchronous reset is retimed to the clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // comparator is analog and asynchronous; a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      comp_s3_q <= 1'b0;
      comp_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_above_i;
      comp_s2_q <= comp_s1_q;
      comp_s3_q <= comp_s2_q;
      if (comp_s2_q == comp_s3_q) begin
        comp_q <= comp_s3_q;
      end
    end
  end

  // agreed value passes without a further flop: a fourth stage would miss the 4-clock bit step
  assign comp_filt = (comp_s2_q == comp_s3_q) ? comp_s3_q : comp_q;

  // every access waits exactly one cycle; read data is captured in that cycle
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_take = avs_write_i & ack_q & avs_byteenable_i[0];
  assign rd_take = avs_read_i & ack_q;
  assign wr_ctrl = wr_take & hit(avs_address_i, CTRL_INDEX);
  assign wr_status = wr_take & hit(avs_address_i, IRQ_STATUS_INDEX);
  assign wr_mask = wr_take & hit(avs_address_i, IRQ_MASK_INDEX);

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // start bit reads back as one while a conversion runs
  assign ctrl_view = {2'b00, chan_q, eoc_q, speed_q, ctl.busy};

  always_comb begin
    rd_mux = 8'h00;
    if (hit(avs_address_i, CTRL_INDEX)) begin
      rd_mux = ctrl_view;
    end else if (hit(avs_address_i, RESULT_INDEX)) begin
      rd_mux = ctl.result;
    end else if (hit(avs_address_i, IRQ_STATUS_INDEX)) begin
      rd_mux = {6'h00, irq_status_q};
    end else if (hit(avs_address_i, IRQ_MASK_INDEX)) begin
      rd_mux = {6'h00, irq_mask_q};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_q) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign avs_readdata_o = rdata_q;

  // channel and speed fields; only bits 5-4 and 2-1 are stored
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chan_q <= CHAN_RESET;
      speed_q <= SPEED_RESET;
    end else if (wr_ctrl) begin
      chan_q <= avs_writedata_i[CHAN_LO +: 2];
      speed_q <= avs_writedata_i[SPEED_LO +: 2];
    end
  end

  // the channel is frozen for the whole run: no sample-and-hold, so it must not move
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      conv_chan_q <= CHAN_RESET;
    end else if (wr_ctrl && !ctl.busy) begin
      conv_chan_q <= avs_writedata_i[CHAN_LO +: 2];
    end else if (!ctl.busy && !start_q) begin
      conv_chan_q <= chan_q;
    end
  end

  // a start written during a run is ignored
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_ctrl & avs_writedata_i[START_BIT] & ~ctl.busy & ~start_q;
    end
  end

  // completion sets the flag and wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      eoc_q <= 1'b0;
    end else if (ctl.done) begin
      eoc_q <= 1'b1;
    end else if (start_q) begin
      eoc_q <= 1'b0;
    end
  end

  // unread result tracking feeds the overrun event
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      unread_q <= 1'b0;
    end else if (ctl.done) begin
      unread_q <= 1'b1;
    end else if (rd_take && hit(avs_address_i, RESULT_INDEX)) begin
      unread_q <= 1'b0;
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_status_q <= IRQ_RESET;
    end else begin
      irq_status_q[IRQ_DONE_BIT] <= ctl.done |
        (irq_status_q[IRQ_DONE_BIT] & ~(wr_status & avs_writedata_i[IRQ_DONE_BIT]));
      irq_status_q[IRQ_OVERRUN_BIT] <= (ctl.done & unread_q) |
        (irq_status_q[IRQ_OVERRUN_BIT] & ~(wr_status & avs_writedata_i[IRQ_OVERRUN_BIT]));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= avs_writedata_i[1:0];
    end
  end

  assign irq_o = |(irq_status_q & irq_mask_q);

  assign ctl.start = start_q;
  assign ctl.speed = speed_q;

  step_divider #(
    .DIV_SPEED1(DIV_SPEED1),
    .DIV_SPEED2(DIV_SPEED2),
    .DIV_SPEED3(DIV_SPEED3)
  ) u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .ctl(ctl.div)
  );

  sar_core u_core (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .comp_above_i(comp_filt),
    .ctl(ctl.seq)
  );

  assign dac_code_o = ctl.sar;
  assign channel_sel_o = conv_chan_q;
  assign converting_o = ctl.busy;
endmodule : sar_adc_sequencer

// >>> verif/comp_model.sv
// comparator and resistor string stand-in for the sar adc sequencer bench
`timescale 1ns/1ps
module comp_model (
  input wire logic [7:0] dac_code_i,
  input wire logic [7:0] level_i,
  output logic comp_above_o
);
  // no sample and hold: the bench keeps the level still for a whole run
  assign comp_above_o = (level_i >= dac_code_i);
endmodule : comp_model

// >>> verif/sar_adc_sequencer_chk.sv
// port checks of the sar adc sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_chk
  import sar_adc_pkg::*;
#(
  parameter int DIV_SPEED1 = 2,
  parameter int DIV_SPEED2 = 4,
  parameter int DIV_SPEED3 = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic comp_above_i,
  input wire logic [7:0] dac_code_o,
  input wire logic [1:0] channel_sel_o,
  input wire logic converting_o,
  input wire logic irq_o
);
  localparam int DIVS [4] = '{1, DIV_SPEED1, DIV_SPEED2, DIV_SPEED3};
  logic ctrl_wr;
  logic [1:0] spd_q;
  logic [11:0] run_q;
  assign ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h3E8
    && avs_byteenable_i[0];
  // speed is only tracked from writes made while idle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spd_q <= 2'h0;
      run_q <= 12'h0;
    end else begin
      if (ctrl_wr && !converting_o) spd_q <= avs_writedata_i[2:1];
      run_q <= converting_o ? run_q + 12'h1 : 12'h0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("new request got no wait cycle");
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("more than one wait cycle");
  a_wait_cause: assert property (avs_waitrequest_o |-> avs_read_i || avs_write_i)
    else $error("wait without request");
  a_ctrl_upper: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h3E8
    |-> avs_readdata_o[31:6] == 26'h0) else $error("unused control bits not zero");
  a_start_conv: assert property (ctrl_wr && avs_writedata_i[0] && !converting_o |-> ##2
    converting_o && dac_code_o == 8'h80 && channel_sel_o == $past(avs_writedata_i[5:4], 2))
    else $error("start did not launch a run");
  a_conv_len: assert property ($fell(converting_o) |-> run_q == 12'(TOTAL_CLOCKS * DIVS[spd_q]))
    else $error("run length wrong");
  a_chan_hold: assert property (converting_o ##1 converting_o |-> $stable(channel_sel_o))
    else $error("channel moved during run");
  a_setup_mid: assert property ($rose(converting_o) |-> (dac_code_o == 8'h80)[*8])
    else $error("trial code not at midpoint in setup");
endmodule : sar_adc_sequencer_chk

// >>> verif/test_sar_adc_sequencer.sv
// self-checking bench of the sar adc sequencer over its register bus
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_sar_adc_sequencer;
  import sar_adc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic comp_above_i;
  logic [7:0] dac_code_o;
  logic [1:0] channel_sel_o;
  logic converting_o;
  logic irq_o;
  logic [7:0] level = 8'h00;
  logic [31:0] rd;
  logic [7:0] lvls [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
  logic [7:0] idxs [5] = '{8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'h10};
  int mismatches = 0;
  int compares = 0;
  sar_adc_sequencer #(.DIV_SPEED1(2), .DIV_SPEED2(3), .DIV_SPEED3(4)) sar_adc_sequencer_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .comp_above_i(comp_above_i),
    .dac_code_o(dac_code_o), .channel_sel_o(channel_sel_o), .converting_o(converting_o),
    .irq_o(irq_o));
  comp_model comp_model_inst (.dac_code_i(dac_code_o), .level_i(level), .comp_above_o(comp_above_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // one full request; held until an edge sees waitrequest low, read data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  function automatic logic [31:0] ctl(logic [1:0] ch, logic [1:0] sp, logic st);
    return {24'h0, 2'b00, ch, 1'b0, sp, st};
  endfunction : ctl
  task automatic poll();
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'hFA, 32'h0, 4'hF);
      if (n == 0) `CHK(rd[0], 1'b1);
      n++;
    end while (rd[3] !== 1'b1 && n < 300);
    if (n >= 300) begin
      mismatches++;
      print_verdict();
    end
  endtask : poll
  task automatic conv(input logic [1:0] ch, input logic [1:0] sp, input logic [7:0] lv);
    level <= lv;
    bus(1'b1, 8'hFA, ctl(ch, sp, 1'b0), 4'hF);
    bus(1'b1, 8'hFA, ctl(ch, sp, 1'b1), 4'hF);
    poll();
  endtask : conv
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    bus(1'b1, 8'h10, 32'hFF, 4'hF);
    foreach (idxs[i]) begin
      bus(1'b0, idxs[i], 32'h0, 4'hF);
      `CHK(rd, 32'h0);
    end
    $display("test reset and unmapped done");
    bus(1'b1, 8'hFD, 32'h1, 4'hF);
    for (int i = 0; i < 4; i++) begin
      conv(2'(i), 2'(i), lvls[i]);
      `CHK(channel_sel_o, 2'(i));
      `CHK(irq_o, 1'b1);
      bus(1'b0, 8'hFA, 32'h0, 4'hF);
      `CHK(rd, ctl(2'(i), 2'(i), 1'b0) | 32'h8);
      bus(1'b0, 8'hFB, 32'h0, 4'hF);
      `CHK(rd, {24'h0, lvls[i]});
      bus(1'b1, 8'hFC, 32'h3, 4'hF);
      @(negedge clk_i);
      `CHK(irq_o, 1'b0);
    end
    $display("test channels and speeds done");
    conv(2'h1, 2'h0, 8'h33);
    conv(2'h1, 2'h0, 8'h44);
    bus(1'b0, 8'hFC, 32'h0, 4'hF);
    `CHK(rd, 32'h3);
    bus(1'b0, 8'hFB, 32'h0, 4'hF);
    `CHK(rd, 32'h44);
    bus(1'b1, 8'hFD, 32'h0, 4'hF);
    @(negedge clk_i);
    `CHK(irq_o, 1'b0);
    bus(1'b1, 8'hFD, 32'h2, 4'hF);
    @(negedge clk_i);
    `CHK(irq_o, 1'b1);
    bus(1'b1, 8'hFC, 32'h3, 4'hF);
    @(negedge clk_i);
    `CHK(irq_o, 1'b0);
    $display("test overwrite and interrupt done");
    bus(1'b1, 8'hFA, ctl(2'h3, 2'h0, 1'b1), 4'hE);
    bus(1'b0, 8'hFA, 32'h0, 4'hF);
    `CHK(converting_o, 1'b0);
    level <= 8'h7F;
    bus(1'b1, 8'hFA, ctl(2'h1, 2'h0, 1'b1), 4'hF);
    bus(1'b1, 8'hFA, ctl(2'h2, 2'h0, 1'b1), 4'hF);
    `CHK(channel_sel_o, 2'h1);
    poll();
    bus(1'b0, 8'hFB, 32'h0, 4'hF);
    `CHK(rd, 32'h7F);
    $display("test refused starts done");
    print_verdict();
  end
endmodule : test_sar_adc_sequencer
bind sar_adc_sequencer sar_adc_sequencer_chk #(.DIV_SPEED1(DIV_SPEED1),
  .DIV_SPEED2(DIV_SPEED2), .DIV_SPEED3(DIV_SPEED3)) chk_inst (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .comp_above_i(comp_above_i),
  .dac_code_o(dac_code_o), .channel_sel_o(channel_sel_o), .converting_o(converting_o),
  .irq_o(irq_o));
